/* inc/dde_map.svh */
`ifndef DDE_MAP_SVH
`define DDE_MAP_SVH

// field geometry
`define DDE_SECT_WORDS 9'd256
`define DDE_HDR_WORDS 9'd2
`define DDE_TRACK_SECTS 6'd32
`define DDE_HDR_SECT_IDX 9'd1

// buffer layout, word addresses in the 1k x 16 store; test end counts 32-bit entries
`define DDE_HDR_ADDR 10'h010
`define DDE_SLOT0_ADDR 10'h200
`define DDE_SLOT1_ADDR 10'h300
`define DDE_TEST_END 10'h200

// check register
`define DDE_ECC_POLY 32'h0040_0801
`define DDE_CRC_POLY 16'h1021
`define DDE_ECC_INIT 32'h0000_0000
`define DDE_CRC_INIT 32'h0000_ffff
`define DDE_ECC_LAST 5'd31
`define DDE_CRC_LAST 5'd15
`define DDE_PAT_W 11
`define DDE_BIT_LAST 4'd15

`endif

/* inc/dde_pkg.sv */
package dde_pkg;

    typedef struct packed {
        logic wr;
        logic hdr;
        logic slot;
        logic [5:0] sect;
    } dde_cmd_s;

    typedef struct packed {
        logic bad_sect;
        logic sec_miss;
        logic crc_err;
        logic ecc_corr;
        logic ecc_unc;
        logic late;
        logic [12:0] err_pos;
        logic [10:0] err_pat;
    } dde_res_s;

    typedef enum logic [5:0] {
        CS_TESTW = 6'h01,
        CS_TESTR = 6'h02,
        CS_FAIL = 6'h04,
        CS_IDLE = 6'h08,
        CS_RUN = 6'h10,
        CS_TRAP = 6'h20
    } dde_cst_e;

    typedef enum logic [3:0] {
        LS_IDLE = 4'h1,
        LS_DATA = 4'h2,
        LS_CHK = 4'h4,
        LS_END = 4'h8
    } dde_lst_e;

endpackage

/* hdl/dde_buf2.sv */
`timescale 1ns/1ps
module dde_buf2 #(
    parameter int W = 16,
    parameter int D = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;

    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_ff;
    logic [AW-1:0] rp_ff;
    logic [AW:0] cnt_ff;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (cnt_ff != (AW+1)'(D));
    assign out_valid = (cnt_ff != '0);
    assign out_data = mem[rp_ff];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_ff] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wp_ff <= (wp_ff == AW'(D-1)) ? '0 : wp_ff + 1'b1;
            end
            if (pop) begin
                rp_ff <= (rp_ff == AW'(D-1)) ? '0 : rp_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule

/* hdl/dde_top.sv */
`timescale 1ns/1ps
`include "dde_map.svh"
// Summary of operation
// [R1] data fields carry a 32-bit code correcting one burst up to 11 bits
// [R2] bursts beyond the correctable length are flagged uncorrectable
// [R3] headers are written and checked with a 16-bit crc
// [R4] one 32-bit shift register does ecc and a 16-bit header mode
// [R5] division runs bit by bit in hardware while the field streams
// [R6] error position and pattern are computed and reported to the host
// [R7] serial read data is assembled into 16-bit words for the buffer
// [R8] words are shifted out serially on the drive's servo clock
// [R9] a data field is exactly 256 words, 512 bytes
// [R10] a track holds 32 sectors; other sector numbers are refused
// [R11] 1k x 16 buffer holds register images plus two sector slots
// [R12] power-up self-test; on failure fault lit and accesses ignored
// [R13] host moves buffer data as 32-bit transfers
// [R14] the shift register is initialised before each field's first bit
module dde_top import dde_pkg::*; #(
    parameter int TRAP_MAX = 4160,
    parameter logic [31:0] ECC_POLY = `DDE_ECC_POLY,
    parameter logic [15:0] CRC_POLY = `DDE_CRC_POLY
) (
    // core clock and reset
    input wire logic clk,
    input wire logic rst,
    // drive link, servo clock from the drive
    input wire logic link_clk,
    input wire logic rd_data,
    output logic rd_gate,
    output logic wr_gate,
    output logic wr_data,
    // transfer command and result
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire dde_cmd_s cmd,
    output logic done,
    output dde_res_s res,
    // controller processor port, 16-bit
    input wire logic cpu_req,
    input wire logic cpu_we,
    input wire logic [9:0] cpu_addr,
    input wire logic [15:0] cpu_wdata,
    output logic cpu_ack,
    output logic [15:0] cpu_rdata,
    // host memory port, 32-bit
    input wire logic host_req,
    input wire logic host_we,
    input wire logic [8:0] host_addr,
    input wire logic [31:0] host_wdata,
    output logic host_ack,
    output logic [31:0] host_rdata,
    // indicators
    output logic fault_led,
    output logic diag_led
);
    function automatic logic [31:0] dde_step(input logic [31:0] s,
                                             input logic d,
                                             input logic hdr);
        logic fb;
        fb = d ^ (hdr ? s[15] : s[31]);
        if (hdr) begin
            dde_step = {16'h0, s[14:0], 1'b0} ^
                       (fb ? {16'h0, CRC_POLY} : '0);
        end else begin
            dde_step = {s[30:0], 1'b0} ^ (fb ? ECC_POLY : 32'h0);
        end
    endfunction

    function automatic logic [31:0] dde_pat(input logic [8:0] a);
        dde_pat = {a, ~a, a, ~a[4:0]};
    endfunction

    // undoes one ecc step; a shortened code cannot be trapped forwards
    function automatic logic [31:0] dde_back(input logic [31:0] s);
        if (s[0]) begin
            dde_back = {1'b1, s[31:1] ^ ECC_POLY[31:1]};
        end else begin
            dde_back = {1'b0, s[31:1]};
        end
    endfunction

    // ---------------- core side state ----------------
    dde_cst_e cst_ff, nxt_cst;
    dde_cmd_s cmd_ff;
    dde_res_s res_ff;
    logic done_ff;
    logic [9:0] t_cnt_ff;
    logic cmp_vld_ff;
    logic [8:0] cmp_a_ff;
    logic fail_ff;
    logic [8:0] xcnt_ff;
    logic fetch_ff;
    logic seen_ff;
    logic dgate_ff;
    logic ovr_ff;
    logic [31:0] trap_ff;
    logic [12:0] tcnt_ff;
    logic [15:0] tx_word_ff;
    logic tx_tgl_ff;
    logic cpu_ack_ff;
    logic host_ack_ff;
    logic hi_sel_ff;
    logic [31:0] rd_ff;
    logic [9:0] dsk_addr_q;
    logic rx_q1, rx_q2, rx_q3;
    logic dn_q1, dn_q2, dn_q3;
    logic ta_q1, ta_q2;

    // ---------------- link side state ----------------
    dde_lst_e lst_ff;
    logic lg_q1, lg_q2;
    logic rd_q1, rd_q2;
    logic [3:0] bit_cnt_ff;
    logic [8:0] wrd_cnt_ff;
    logic [4:0] chk_cnt_ff;
    logic [31:0] sr_ff;
    logic [15:0] sh_ff;
    logic [15:0] rx_word_ff;
    logic rx_tgl_ff;
    logic done_tgl_ff;
    logic txa_tgl_ff;
    logic tq1, tq2;
    logic late_ff;
    logic wout_ff;

    // ---------------- crossings into core ----------------
    wire rx_ev = rx_q2 ^ rx_q3;
    wire dn_ev = dn_q2 ^ dn_q3;
    wire tx_pend = tx_tgl_ff ^ ta_q2;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {rx_q1, rx_q2, rx_q3} <= 3'h0;
            {dn_q1, dn_q2, dn_q3} <= 3'h0;
            {ta_q1, ta_q2} <= 2'h0;
        end else begin
            {rx_q1, rx_q2, rx_q3} <= {rx_tgl_ff, rx_q1, rx_q2};
            {dn_q1, dn_q2, dn_q3} <= {done_tgl_ff, dn_q1, dn_q2};
            {ta_q1, ta_q2} <= {txa_tgl_ff, ta_q1};
        end
    end

    // ---------------- field geometry ----------------
    wire [8:0] fld_len = cmd_ff.hdr ? `DDE_HDR_WORDS : `DDE_SECT_WORDS; // [R9]
    wire [9:0] fld_base = cmd_ff.hdr ? `DDE_HDR_ADDR :
                          (cmd_ff.slot ? `DDE_SLOT1_ADDR : `DDE_SLOT0_ADDR);
    wire [9:0] dsk_addr = fld_base + {1'b0, xcnt_ff}; // [R11]
    wire moved_all = (xcnt_ff == fld_len);
    wire open_port = (cst_ff == CS_IDLE) || (cst_ff == CS_RUN) ||
                     (cst_ff == CS_TRAP);

    // ---------------- buffer arbitration ----------------
    wire in_test = (cst_ff == CS_TESTW) || (cst_ff == CS_TESTR);
    wire t_issue = in_test && (t_cnt_ff != `DDE_TEST_END);
    wire cpu_gnt = open_port && cpu_req && !cpu_ack_ff; // [R12]
    wire host_gnt = open_port && host_req && !host_ack_ff && !cpu_gnt;
    wire dsk_gnt = (cst_ff == CS_RUN) && !cpu_gnt && !host_gnt;

    // read path: link words -> two-entry buffer -> store
    // write path: store -> two-entry buffer -> link hand-over register
    wire bf_in_ready;
    wire bf_out_valid;
    wire [15:0] bf_out_data;
    wire fetch_go = dsk_gnt && cmd_ff.wr && !fetch_ff && bf_in_ready &&
                    !moved_all;
    wire [15:0] fetch_word = dsk_addr_q[0] ? rd_ff[31:16] : rd_ff[15:0];
    wire bf_in_valid = cmd_ff.wr ? fetch_ff : (rx_ev && cst_ff == CS_RUN);
    wire [15:0] bf_in_data = cmd_ff.wr ? fetch_word : rx_word_ff;
    wire bf_out_ready = cmd_ff.wr ? !tx_pend : dsk_gnt;
    wire dsk_wr = !cmd_ff.wr && bf_out_valid && dsk_gnt && !moved_all;

    dde_buf2 #(.W(16), .D(2)) u_buf (
        .clk(clk),
        .rst(rst),
        .in_valid(bf_in_valid),
        .in_ready(bf_in_ready),
        .in_data(bf_in_data),
        .out_valid(bf_out_valid),
        .out_ready(bf_out_ready),
        .out_data(bf_out_data)
    );

    wire [8:0] ram_idx = t_issue ? t_cnt_ff[8:0] :
                         cpu_gnt ? cpu_addr[9:1] :
                         host_gnt ? host_addr : dsk_addr[9:1];
    wire [1:0] cpu_lane = cpu_addr[0] ? 2'b10 : 2'b01;
    wire [1:0] dsk_lane = dsk_addr[0] ? 2'b10 : 2'b01;
    wire [1:0] ram_we = (t_issue && cst_ff == CS_TESTW) ? 2'b11 :
                        (cpu_gnt && cpu_we) ? cpu_lane :
                        (host_gnt && host_we) ? 2'b11 : // [R13]
                        dsk_wr ? dsk_lane : 2'b00;
    wire [31:0] ram_wd = t_issue ? dde_pat(t_cnt_ff[8:0]) :
                         cpu_gnt ? {cpu_wdata, cpu_wdata} :
                         host_gnt ? host_wdata :
                         {bf_out_data, bf_out_data};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_lane
            // one store per 16-bit lane, so each has a single writer
            logic [15:0] mem [512];
            always_ff @(posedge clk) begin
                if (ram_we[g]) begin
                    mem[ram_idx] <= ram_wd[g*16 +: 16];
                end
                rd_ff[g*16 +: 16] <= mem[ram_idx];
            end
        end
    endgenerate

    assign cpu_rdata = hi_sel_ff ? rd_ff[31:16] : rd_ff[15:0];
    assign host_rdata = rd_ff;
    assign cpu_ack = cpu_ack_ff;
    assign host_ack = host_ack_ff;
    assign fault_led = (cst_ff == CS_FAIL); // [R12]
    assign diag_led = in_test;
    assign cmd_ready = (cst_ff == CS_IDLE);
    assign done = done_ff;
    assign res = res_ff;
    assign rd_gate = dgate_ff && !cmd_ff.wr;
    assign wr_gate = dgate_ff && cmd_ff.wr;

    // ---------------- core sequencer ----------------
    wire test_last = (t_cnt_ff == `DDE_TEST_END) && !cmp_vld_ff;
    wire mis = cmp_vld_ff && (rd_ff != dde_pat(cmp_a_ff));
    wire run_end = seen_ff && moved_all && !bf_out_valid;
    wire syn_zero = cmd_ff.hdr ? (sr_ff[15:0] == 16'h0) : (sr_ff == 32'h0);
    wire trap_hit = (trap_ff[31:`DDE_PAT_W] == '0);
    wire trap_out = (tcnt_ff == 13'(TRAP_MAX - 1));
    wire cmd_go = cmd_valid && (cst_ff == CS_IDLE);
    wire sect_ok = (cmd.sect < `DDE_TRACK_SECTS); // [R10]

    always_comb begin
        nxt_cst = cst_ff;
        case (cst_ff)
            CS_TESTW: if (t_cnt_ff == `DDE_TEST_END) nxt_cst = CS_TESTR;
            CS_TESTR: if (test_last) nxt_cst = fail_ff ? CS_FAIL : CS_IDLE;
            CS_FAIL: nxt_cst = CS_FAIL;
            CS_IDLE: if (cmd_go && sect_ok) nxt_cst = CS_RUN;
            CS_RUN: begin
                if (run_end) begin
                    nxt_cst = (cmd_ff.wr || cmd_ff.hdr || syn_zero) ?
                              CS_IDLE : CS_TRAP;
                end
            end
            CS_TRAP: if (trap_hit || trap_out) nxt_cst = CS_IDLE;
            default: nxt_cst = CS_TESTW;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cst_ff <= CS_TESTW;
            t_cnt_ff <= 10'h0;
            cmp_vld_ff <= 1'b0;
            cmp_a_ff <= 9'h0;
            fail_ff <= 1'b0;
        end else begin
            cst_ff <= nxt_cst;
            cmp_vld_ff <= t_issue && (cst_ff == CS_TESTR);
            cmp_a_ff <= t_cnt_ff[8:0];
            if (mis) fail_ff <= 1'b1; // [R12]
            if (cst_ff == CS_TESTW && t_cnt_ff == `DDE_TEST_END) begin
                t_cnt_ff <= 10'h0;
            end else if (t_issue) begin
                t_cnt_ff <= t_cnt_ff + 10'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_ff <= '0;
            xcnt_ff <= 9'h0;
            fetch_ff <= 1'b0;
            dsk_addr_q <= 10'h0;
            seen_ff <= 1'b0;
            dgate_ff <= 1'b0;
            ovr_ff <= 1'b0;
            tx_word_ff <= 16'h0;
            tx_tgl_ff <= 1'b0;
            cpu_ack_ff <= 1'b0;
            host_ack_ff <= 1'b0;
            hi_sel_ff <= 1'b0;
        end else begin
            cpu_ack_ff <= cpu_gnt;
            host_ack_ff <= host_gnt;
            if (cpu_gnt) hi_sel_ff <= cpu_addr[0];
            fetch_ff <= fetch_go;
            dsk_addr_q <= dsk_addr;
            if (cmd_go) begin
                cmd_ff <= cmd;
                xcnt_ff <= 9'h0;
                seen_ff <= 1'b0;
                ovr_ff <= 1'b0;
            end
            if (fetch_go || dsk_wr) xcnt_ff <= xcnt_ff + 9'h1;
            // disk cannot wait: a word with no room is a data-late error
            if (bf_in_valid && !bf_in_ready) ovr_ff <= 1'b1;
            if (cmd_ff.wr && bf_out_valid && !tx_pend) begin // [R8]
                tx_word_ff <= bf_out_data;
                tx_tgl_ff <= ~tx_tgl_ff;
            end
            // write gate waits for the first word to be handed over
            if (cst_ff == CS_RUN && !seen_ff && (!cmd_ff.wr || tx_pend)) begin
                dgate_ff <= 1'b1;
            end
            if (dn_ev && cst_ff == CS_RUN) begin
                dgate_ff <= 1'b0;
                seen_ff <= 1'b1;
            end
        end
    end

    // ---------------- result and burst trapping ----------------
    wire hdr_sect_wr = dsk_wr && cmd_ff.hdr && (xcnt_ff == `DDE_HDR_SECT_IDX);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            res_ff <= '0;
            done_ff <= 1'b0;
            trap_ff <= 32'h0;
            tcnt_ff <= 13'h0;
        end else begin
            done_ff <= 1'b0;
            if (cmd_go) begin
                res_ff <= '0;
                res_ff.bad_sect <= !sect_ok; // [R10]
                done_ff <= !sect_ok;
            end
            if (hdr_sect_wr && bf_out_data[5:0] != cmd_ff.sect) begin
                res_ff.sec_miss <= 1'b1;
            end
            if (cst_ff == CS_RUN && run_end) begin
                trap_ff <= sr_ff;
                tcnt_ff <= 13'h0;
                res_ff.late <= ovr_ff || late_ff;
                res_ff.crc_err <= cmd_ff.hdr && !cmd_ff.wr && // [R3]
                                  !syn_zero;
                done_ff <= cmd_ff.wr || cmd_ff.hdr || syn_zero;
            end
            if (cst_ff == CS_TRAP) begin
                if (trap_hit) begin // [R6]
                    res_ff.ecc_corr <= 1'b1; // [R1]
                    res_ff.err_pos <= tcnt_ff;
                    res_ff.err_pat <= trap_ff[`DDE_PAT_W-1:0];
                    done_ff <= 1'b1;
                end else if (trap_out) begin
                    res_ff.ecc_unc <= 1'b1; // [R2]
                    done_ff <= 1'b1;
                end else begin
                    trap_ff <= dde_back(trap_ff); // [R6]
                    tcnt_ff <= tcnt_ff + 13'h1;
                end
            end
        end
    end

    // ---------------- link domain ----------------
    wire lhdr = cmd_ff.hdr;
    wire lwr = cmd_ff.wr;
    wire [8:0] l_last_wd = fld_len - 9'h1;
    wire [4:0] l_last_ck = lhdr ? `DDE_CRC_LAST : `DDE_ECC_LAST;
    wire take_tx = (tq2 != txa_tgl_ff);
    wire [15:0] cur_word = (bit_cnt_ff == 4'h0) ?
                           (take_tx ? tx_word_ff : 16'h0) : sh_ff;
    wire in_bit = rd_q2;
    wire d_bit = lwr ? cur_word[15] : in_bit;
    wire ck_top = lhdr ? sr_ff[15] : sr_ff[31];
    wire [31:0] ck_shift = lhdr ? {16'h0, sr_ff[14:0], 1'b0}
                                : {sr_ff[30:0], 1'b0};
    wire bit_end = (bit_cnt_ff == `DDE_BIT_LAST);
    wire fld_end = bit_end && (wrd_cnt_ff == l_last_wd);

    assign wr_data = wout_ff;

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            {lg_q1, lg_q2} <= 2'h0;
            {rd_q1, rd_q2} <= 2'h0;
            {tq1, tq2} <= 2'h0;
        end else begin
            {lg_q1, lg_q2} <= {dgate_ff, lg_q1};
            {rd_q1, rd_q2} <= {rd_data, rd_q1};
            {tq1, tq2} <= {tx_tgl_ff, tq1};
        end
    end

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            lst_ff <= LS_IDLE;
            bit_cnt_ff <= 4'h0;
            wrd_cnt_ff <= 9'h0;
            chk_cnt_ff <= 5'h0;
            sr_ff <= 32'h0;
            sh_ff <= 16'h0;
            rx_word_ff <= 16'h0;
            rx_tgl_ff <= 1'b0;
            done_tgl_ff <= 1'b0;
            txa_tgl_ff <= 1'b0;
            late_ff <= 1'b0;
            wout_ff <= 1'b0;
        end else begin
            wout_ff <= 1'b0;
            case (lst_ff)
                LS_IDLE: begin
                    if (lg_q2) begin
                        sr_ff <= lhdr ? `DDE_CRC_INIT : `DDE_ECC_INIT; // [R14]
                        bit_cnt_ff <= 4'h0;
                        wrd_cnt_ff <= 9'h0;
                        chk_cnt_ff <= 5'h0;
                        late_ff <= 1'b0;
                        lst_ff <= LS_DATA;
                    end
                end
                LS_DATA: begin
                    sr_ff <= dde_step(sr_ff, d_bit, lhdr); // [R5]
                    bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    if (lwr) begin
                        wout_ff <= cur_word[15]; // [R8]
                        sh_ff <= {cur_word[14:0], 1'b0};
                        if (bit_cnt_ff == 4'h0) begin
                            if (take_tx) txa_tgl_ff <= ~txa_tgl_ff;
                            else late_ff <= 1'b1;
                        end
                    end else begin
                        sh_ff <= {sh_ff[14:0], in_bit};
                        if (bit_end) begin
                            rx_word_ff <= {sh_ff[14:0], in_bit}; // [R7]
                            rx_tgl_ff <= ~rx_tgl_ff;
                        end
                    end
                    if (bit_end) wrd_cnt_ff <= wrd_cnt_ff + 9'h1;
                    if (fld_end) lst_ff <= LS_CHK;
                end
                LS_CHK: begin
                    chk_cnt_ff <= chk_cnt_ff + 5'h1;
                    if (lwr) begin
                        wout_ff <= ck_top; // [R1] [R3]
                        sr_ff <= ck_shift;
                    end else begin
                        sr_ff <= dde_step(sr_ff, in_bit, lhdr); // [R4]
                    end
                    if (chk_cnt_ff == l_last_ck) begin
                        done_tgl_ff <= ~done_tgl_ff;
                        lst_ff <= LS_END;
                    end
                end
                LS_END: if (!lg_q2) lst_ff <= LS_IDLE;
                default: lst_ff <= LS_IDLE;
            endcase
        end
    end
endmodule

/* sim/dde_drive.sv */
`timescale 1ns/1ps
module dde_drive (
    // link
    output logic link_clk = 1'b0,
    input wire logic wr_gate,
    input wire logic wr_data,
    input wire logic rd_gate,
    output logic rd_data = 1'b0
);
    logic trk [0:4127];
    int n = 0;
    // servo clock runs free, unrelated to the core clock
    initial begin
        #37;
        forever #80 link_clk = ~link_clk;
    end
    // first write bit leaves on the 4th gated edge
    always @(posedge link_clk) begin
        if (wr_gate && n >= 4 && n < 4132)
            trk[n-4] = wr_data;
        n = (wr_gate || rd_gate) ? n + 1 : 0;
    end
    // first read bit on the pin at the 2nd gated edge; toggle when idle
    always @(negedge link_clk)
        rd_data <= (rd_gate && n > 0 && n <= 4128) ? trk[n-1] : !rd_data;
endmodule

/* sim/dde_top_sva.sv */
`timescale 1ns/1ps
module dde_top_sva import dde_pkg::*; (
    // core
    input wire logic clk,
    input wire logic rst,
    // link and command
    input wire logic rd_gate,
    input wire logic wr_gate,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire dde_cmd_s cmd,
    input wire logic done,
    input wire dde_res_s res,
    // access ports and indicators
    input wire logic cpu_req,
    input wire logic cpu_ack,
    input wire logic host_ack,
    input wire logic fault_led,
    input wire logic diag_led
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    cpu_ack_one_a: assert property (
        cpu_ack |-> $past(cpu_req) ##1 !cpu_ack)
        else $error("cpu ack without request or held");
    one_port_a: assert property (!(cpu_ack && host_ack))
        else $error("both ports acked");
    test_mute_a: assert property ($past(diag_led) || fault_led
        |-> !cpu_ack && !host_ack) else $error("access acked in test");
    fail_idle_a: assert property (fault_led |-> !cmd_ready && !diag_led)
        else $error("failed unit accepts commands");
    gate_excl_a: assert property (!(rd_gate && wr_gate))
        else $error("both gates high");
    gate_busy_a: assert property (rd_gate || wr_gate |-> !cmd_ready)
        else $error("ready while framing");
    bad_sect_a: assert property (cmd_valid && cmd_ready
        && cmd.sect >= 6'd32 |-> ##[1:2] done && res.bad_sect)
        else $error("bad sector not refused");
    ecc_excl_a: assert property (
        done |-> !(res.ecc_corr && res.ecc_unc))
        else $error("corrected and uncorrectable");
    done_one_a: assert property (done |=> !done)
        else $error("done longer than a cycle");
endmodule
bind dde_top dde_top_sva u_sva (.clk(clk), .rst(rst), .rd_gate(rd_gate),
    .wr_gate(wr_gate), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd(cmd), .done(done), .res(res), .cpu_req(cpu_req),
    .cpu_ack(cpu_ack), .host_ack(host_ack), .fault_led(fault_led),
    .diag_led(diag_led));

/* sim/dde_top_test.sv */
`timescale 1ns/1ps
`include "dde_map.svh"
module dde_top_test import dde_pkg::*;;
    logic clk = 0, rst = 1, link_clk, rd_data, rd_gate, wr_gate, wr_data;
    logic cmd_valid = 0, cmd_ready, done, cpu_req = 0, cpu_we = 0;
    logic cpu_ack, host_req = 0, host_we = 0, host_ack, fault_led, diag_led;
    logic [9:0] cpu_addr = 0;
    logic [8:0] host_addr = 0;
    logic [15:0] cpu_wdata = 0, cpu_rdata;
    logic [31:0] host_wdata = 0, host_rdata, q;
    dde_cmd_s cmd = '0;
    dde_res_s res;
    int miscompares = 0, total_checks = 0;
    dde_top u_dut (.clk(clk), .rst(rst), .link_clk(link_clk),
        .rd_data(rd_data), .rd_gate(rd_gate), .wr_gate(wr_gate),
        .wr_data(wr_data), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd(cmd), .done(done), .res(res), .cpu_req(cpu_req),
        .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata), .host_req(host_req),
        .host_we(host_we), .host_addr(host_addr), .host_wdata(host_wdata),
        .host_ack(host_ack), .host_rdata(host_rdata),
        .fault_led(fault_led), .diag_led(diag_led));
    dde_drive u_drv (.link_clk(link_clk), .wr_gate(wr_gate),
        .wr_data(wr_data), .rd_gate(rd_gate), .rd_data(rd_data));
    initial forever #50 clk = ~clk;
    function automatic logic [15:0] pat(input int i);
        return {i[7:0], ~i[7:0]} ^ 16'h5a00;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input bit h, input bit we, input logic [9:0] a,
                       input logic [31:0] d, output bit ok);
        int t;
        t = 0;
        @(negedge clk);
        cpu_req = !h;
        host_req = h;
        cpu_we = we;
        host_we = we;
        cpu_addr = a;
        host_addr = a[8:0];
        cpu_wdata = d[15:0];
        host_wdata = d;
        do @(posedge clk); while (!(cpu_ack || host_ack) && ++t < 40);
        ok = cpu_ack || host_ack;
        q = h ? host_rdata : {16'h0000, cpu_rdata};
        @(negedge clk);
        cpu_req = 0;
        host_req = 0;
    endtask
    task automatic run(input logic [8:0] c);
        int t;
        t = 0;
        @(negedge clk);
        cmd = c;
        cmd_valid = 1;
        do @(posedge clk); while (!cmd_ready && ++t < 50);
        @(negedge clk);
        cmd_valid = 0;
        t = 0;
        do @(posedge clk); while (!done && ++t < 20000);
        chk(done, 1);
        @(negedge clk);
    endtask
    task automatic results;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic t_selftest;
        bit ok;
        int t;
        t = 0;
        acc(0, 0, 10'h200, 0, ok);
        chk(ok, 0);
        chk(diag_led, 1);
        while (!cmd_ready && t < 3000) begin
            @(posedge clk);
            t++;
        end
        @(negedge clk);
        chk({fault_led, diag_led, cmd_ready}, 3'b001);
    endtask
    task automatic t_bus;
        bit ok;
        acc(0, 1, 10'h3fe, 32'h1234, ok);
        acc(0, 1, 10'h3ff, 32'habcd, ok);
        acc(1, 0, 10'h1ff, 0, ok);
        chk(q, 32'habcd_1234);
        acc(1, 1, 10'h000, 32'h8765_4321, ok);
        acc(0, 0, 10'h001, 0, ok);
        chk(q, 32'h8765);
    endtask
    task automatic t_write;
        bit ok;
        logic [31:0] r, c;
        logic [15:0] w;
        int i, e;
        r = `DDE_ECC_INIT;
        e = 0;
        for (i = 0; i < 128; i++)
            acc(1, 1, 10'(9'h100 + i), {pat(2*i+1), pat(2*i)}, ok);
        run({3'b100, 6'd3});
        for (i = 0; i < 4096; i++) begin
            w = pat(i / 16);
            e += (u_drv.trk[i] !== w[15 - i % 16]);
            r = {r[30:0], 1'b0} ^
                ((w[15 - i % 16] ^ r[31]) ? `DDE_ECC_POLY : 0);
        end
        for (i = 0; i < 32; i++)
            c = {c[30:0], u_drv.trk[4096 + i]};
        chk(e, 0);
        chk(c, r);
    endtask
    task automatic t_read;
        bit ok;
        int i;
        run({3'b001, 6'd3});
        chk({res.ecc_corr, res.ecc_unc, res.late}, 0);
        for (i = 0; i < 128; i++) begin
            acc(1, 0, 10'(9'h180 + i), 0, ok);
            chk(q, {pat(2*i+1), pat(2*i)});
        end
    endtask
    // bursts flipped on the stored track, put back afterwards
    task automatic t_err(input int at, input int len, input logic [1:0] x);
        int i;
        for (i = at; i < at + len; i++)
            u_drv.trk[i] = !u_drv.trk[i];
        run({3'b001, 6'd3});
        chk({res.ecc_corr, res.ecc_unc}, x);
        // window of 11 bits starts at the burst's first bit of 4128 + 21
        if (len <= 11) begin
            chk(res.err_pat, 11'(11'h7ff << (11 - len)));
            chk(res.err_pos, 13'(4149 - at));
        end
        for (i = at; i < at + len; i++)
            u_drv.trk[i] = !u_drv.trk[i];
    endtask
    task automatic t_bad;
        run({3'b001, 6'd32});
        chk(res.bad_sect, 1);
    endtask
    task automatic t_hdr;
        bit ok;
        acc(0, 1, 10'h010, 32'h0123, ok);
        acc(0, 1, 10'h011, 32'h0005, ok);
        run({3'b110, 6'd5});
        run({3'b010, 6'd5});
        chk({res.crc_err, res.sec_miss}, 2'b00);
        run({3'b010, 6'd6});
        chk({res.crc_err, res.sec_miss}, 2'b01);
        u_drv.trk[3] = !u_drv.trk[3];
        run({3'b010, 6'd5});
        chk(res.crc_err, 1);
    endtask
    initial begin
        #8_000_000;
        miscompares++;
        results();
    end
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 0;
        t_selftest();
        t_bus();
        t_write();
        t_read();
        t_err(100, 1, 2'b10);
        t_err(2000, 11, 2'b10);
        t_err(3000, 24, 2'b01);
        t_bad();
        t_hdr();
        results();
    end
endmodule
